// file: logic/sadc_defs.svh
`ifndef SADC_DEFS_SVH
`define SADC_DEFS_SVH

// Clock period in ps (125 MHz)
`define SADC_CLK_PS 8000
// Typical conversion time in ns
`define SADC_TCONV_TYP_NS 2470
// Longest conversion time in ns
`define SADC_TCONV_MAX_NS 2700
// Longest acquisition time in ns
`define SADC_TACQ_MAX_NS 300
// Least gap from valid data to busy rise in ns
`define SADC_TDB_MIN_NS 25
// Typical busy delay after end of conversion in ns
`define SADC_TDBE_TYP_NS 100
// Least data hold after read/convert falls in ns
`define SADC_THDR_MIN_NS 20
// Longest delay to high impedance in ns
`define SADC_THL_MAX_NS 150
// Result width in bits
`define SADC_RES_W 12
// Oscillator ticks per bit decision (cycles)
`define SADC_TICK_CYC 24
// Cycles of the typical busy delay after end of conversion (rounded down)
`define SADC_TDBE_CYC ((`SADC_TDBE_TYP_NS * 1000) / `SADC_CLK_PS)
// Least cycles from valid data to busy rise (rounded up)
`define SADC_TDB_CYC ((`SADC_TDB_MIN_NS * 1000 + `SADC_CLK_PS - 1) / `SADC_CLK_PS)

`endif

// file: logic/sadc_pkg.sv
package sadc_pkg;
    // Converter sequencer states, one-hot
    typedef enum logic [2:0] {
        SADC_IDLE = 3'b001,
        SADC_CONV = 3'b010,
        SADC_XFER = 3'b100
    } sadc_state_e;
    typedef logic [11:0] sadc_word_t;
endpackage

// file: logic/sadc_sar_if.sv
`timescale 1ns/100ps
// Link between the control block and the bit sequencer
interface sadc_sar_if;
    logic start;
    logic cmp;
    logic done;
    logic [11:0] result;
    modport ctrl (output start, output cmp, input done, input result);
    modport sar (input start, input cmp, output done, output result);
endinterface

// file: logic/sadc_sar.sv
`timescale 1ns/100ps
`include "sadc_defs.svh"
module sadc_sar
    import sadc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    sadc_sar_if.sar sif
);
    logic [4:0] tick_r;
    logic [3:0] bit_r;
    logic run_r;
    logic done_r;
    sadc_word_t trial_r;

    // Internal oscillator tick divider
    always_ff @(posedge clk) begin
        if (reset || !run_r || tick_r == 5'(`SADC_TICK_CYC - 1)) begin
            tick_r <= 5'h00;
        end else begin
            tick_r <= tick_r + 5'h01;
        end
    end

    // Twelve bit decisions, most significant first
    always_ff @(posedge clk) begin
        done_r <= 1'b0;
        if (reset) begin
            run_r <= 1'b0;
            bit_r <= 4'h0;
            trial_r <= 12'h000;
        end else if (sif.start && !run_r) begin
            run_r <= 1'b1;
            bit_r <= 4'hb;
            trial_r <= 12'h800;
        end else if (run_r && tick_r == 5'(`SADC_TICK_CYC - 1)) begin
            trial_r[bit_r] <= sif.cmp;
            if (bit_r == 4'h0) begin
                run_r <= 1'b0;
                done_r <= 1'b1;
            end else begin
                trial_r[bit_r - 4'h1] <= 1'b1;
                bit_r <= bit_r - 4'h1;
            end
        end
    end

    assign sif.done = done_r;
    // Last decision already sits in trial_r when done is seen
    assign sif.result = trial_r;
endmodule // sadc_sar

// file: logic/sadc_ctrl.sv
`timescale 1ns/100ps
`include "sadc_defs.svh"
module sadc_ctrl
    import sadc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic read_conv,
    input wire logic sel_n,
    input wire logic upper_byte_sel,
    input wire logic cmp,
    output logic busy_n,
    output logic track,
    output logic [11:0] data_out,
    output logic [11:0] data_oe
);
    // ************************************************************
    // Conversion control
    // ************************************************************
    localparam int XFER_CYC = `SADC_TDBE_CYC;
    localparam int TDB_CYC = `SADC_TDB_CYC;

    sadc_sar_if sif ();
    sadc_state_e state_r;
    logic rc_d_r;
    logic [3:0] xfer_r;
    sadc_word_t result_r;
    logic busy_n_r;
    logic track_r;
    logic [11:0] data_r;
    logic [11:0] oe_r;
    logic start;

    // Start decode shared by sequencer and checks
    function automatic logic start_ok(input logic rc_prev, input logic rc, input logic sn,
                                      input logic ub, input logic bn);
        return rc_prev && !rc && !sn && !ub && bn;
    endfunction

    assign start = start_ok(rc_d_r, read_conv, sel_n, upper_byte_sel, busy_n_r);
    assign sif.start = (state_r == SADC_IDLE) && start;
    assign sif.cmp = cmp;

    sadc_sar u_sar (
        .clk(clk),
        .reset(reset),
        .sif(sif)
    );

    // Edge history of read/convert
    always_ff @(posedge clk) begin
        if (reset) begin
            rc_d_r <= 1'b0;
        end else begin
            rc_d_r <= read_conv;
        end
    end

    // Sequencer: idle, converting, transfer delay
    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= SADC_IDLE;
            xfer_r <= 4'h0;
        end else begin
            case (state_r)
                SADC_IDLE: begin
                    if (start) begin
                        state_r <= SADC_CONV;
                    end
                end
                SADC_CONV: begin
                    if (sif.done) begin
                        state_r <= SADC_XFER;
                        xfer_r <= 4'h0;
                    end
                end
                SADC_XFER: begin
                    if (xfer_r == 4'(XFER_CYC - 1)) begin
                        state_r <= SADC_IDLE;
                    end else begin
                        xfer_r <= xfer_r + 4'h1;
                    end
                end
                default: state_r <= SADC_IDLE;
            endcase
        end
    end

    // Result latch at internal end of conversion
    always_ff @(posedge clk) begin
        if (reset) begin
            result_r <= 12'h000;
        end else if (state_r == SADC_CONV && sif.done) begin
            result_r <= sif.result;
        end
    end

    // Busy and tracking flags
    always_ff @(posedge clk) begin
        if (reset) begin
            busy_n_r <= 1'b1;
            track_r <= 1'b1;
        end else begin
            if (start) begin
                busy_n_r <= 1'b0;
            end else if (state_r == SADC_XFER && xfer_r == 4'(XFER_CYC - 1)) begin
                busy_n_r <= 1'b1;
            end
            if (start) begin
                track_r <= 1'b0;
            end else if (state_r == SADC_CONV && sif.done) begin
                track_r <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Output drivers
    // ************************************************************
    // Enable and byte steering, one clock from the pins
    always_ff @(posedge clk) begin
        if (reset) begin
            oe_r <= 12'h000;
            data_r <= 12'h000;
        end else if (read_conv && busy_n_r && !sel_n && state_r == SADC_IDLE) begin
            if (upper_byte_sel) begin
                oe_r <= 12'h0ff;
                data_r <= {4'h0, result_r[11:8], 4'h0};
            end else begin
                oe_r <= 12'hfff;
                data_r <= result_r;
            end
        end else begin
            oe_r <= 12'h000;
        end
    end

    assign busy_n = busy_n_r;
    assign track = track_r;
    assign data_out = data_r;
    assign data_oe = oe_r;

    // ************************************************************
    // Checks
    // ************************************************************
    AST_START_BUSY: assert property (@(posedge clk) disable iff (reset)
        start |=> !busy_n) else $error("busy not low after start");
    AST_NO_SPURIOUS: assert property (@(posedge clk) disable iff (reset)
        $fell(busy_n) |-> $past(rc_d_r) && !$past(read_conv) && !$past(sel_n)
        && !$past(upper_byte_sel)) else $error("start without valid edge");
    AST_BUSY_STATE: assert property (@(posedge clk) disable iff (reset)
        busy_n == (state_r == SADC_IDLE)) else $error("busy disagrees with state");
    AST_OE_OFF_CONV: assert property (@(posedge clk) disable iff (reset)
        !busy_n |=> data_oe == 12'h000) else $error("drivers on during conversion");
    AST_CONV_LEN: assert property (@(posedge clk) disable iff (reset)
        $fell(busy_n) |-> !busy_n [*8] ##[1:330] busy_n) else $error("conversion too long");
    AST_TRACK: assert property (@(posedge clk) disable iff (reset)
        $rose(track) |-> !busy_n) else $error("tracking not before busy rise");
    AST_OE_COND: assert property (@(posedge clk) disable iff (reset)
        data_oe != 12'h000 |-> $past(read_conv) && $past(busy_n) && !$past(sel_n))
        else $error("drivers on without conditions");
    AST_HIBYTE: assert property (@(posedge clk) disable iff (reset)
        data_oe == 12'h0ff |-> data_out[3:0] == 4'h0 && data_out[11:8] == 4'h0)
        else $error("upper byte lanes wrong");
    AST_OFF_FAST: assert property (@(posedge clk) disable iff (reset)
        $fell(read_conv) || $rose(sel_n) |=> data_oe == 12'h000)
        else $error("drivers not released");
    AST_XFER_GAP: assert property (@(posedge clk) disable iff (reset)
        $rose(busy_n) |-> $past(state_r, TDB_CYC) == SADC_XFER)
        else $error("busy rose too soon after data");
endmodule // sadc_ctrl

// file: verification/sadc_cmp_model.sv
`timescale 1ns/100ps
// ****************
// Comparator model
// ****************
module sadc_cmp_model (
    input wire logic clk,
    input wire logic busy_n,
    input wire logic [11:0] target,
    output logic cmp
);
    int cnt;
    // Cycles since conversion start
    always_ff @(posedge clk) begin
        cnt <= busy_n ? 0 : cnt + 1;
    end
    // One target bit per tick, MSB first
    assign cmp = target[11 - ((cnt / 24) % 12)];
endmodule // sadc_cmp_model

// file: verification/sar_adc_conversion_control_test.sv
`timescale 1ns/100ps
`include "sadc_defs.svh"
// *************
// Bench top
// *************
module sar_adc_conversion_control_test;
    logic clk = 0, reset = 1, read_conv = 1, sel_n = 0, ub = 0, cmp, busy_n, track;
    logic [11:0] data_out, data_oe, code = 12'h000;
    int errors = 0, cmp_count = 0, cyc = 0;
    sadc_cmp_model u_sadc_cmp_model (.clk(clk), .busy_n(busy_n), .target(code), .cmp(cmp));
    sadc_ctrl u_sadc_ctrl (.clk(clk), .reset(reset), .read_conv(read_conv), .sel_n(sel_n),
        .upper_byte_sel(ub), .cmp(cmp), .busy_n(busy_n), .track(track),
        .data_out(data_out), .data_oe(data_oe));
    // Clock and hang guard
    initial begin
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            give_verdict();
        end
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    // Wait out a conversion, poking inputs midway
    task automatic run_conv(input logic poke, input int pre);
        int n;
        int tr;
        int lim;
        n = 0;
        tr = 0;
        lim = `SADC_TCONV_MAX_NS * 1000 / `SADC_CLK_PS;
        while (busy_n !== 1'b1 && n < 400) begin
            chk("oe_conv", 12'h000, data_oe);
            if (poke && n == 60) begin
                read_conv = ~read_conv;
                sel_n = 1;
            end
            if (poke && n == 70) begin
                read_conv = ~read_conv;
                sel_n = 0;
            end
            if (track === 1'b1 && tr == 0) tr = n;
            step(1);
            n++;
        end
        chk("conv_long", 1, n + pre >= 12 * `SADC_TICK_CYC && n + pre <= lim);
        chk("track_first", 1, tr > 0 && tr < n);
        chk("busy_gap", 12'(`SADC_TDBE_CYC), 12'(n - tr));
    endtask
    // Read the whole word, then the upper byte, then deselect
    task automatic rd_bytes(input logic [11:0] v);
        step(2);
        chk("oe_word", 12'hfff, data_oe);
        chk("word", v, data_out);
        ub = 1;
        step(2);
        chk("oe_hi", 12'h0ff, data_oe);
        chk("hi", {4'h0, v[11:8], 4'h0}, data_out);
        ub = 0;
        sel_n = 1;
        step(2);
        chk("oe_off", 12'h000, data_oe);
        sel_n = 0;
        step(4);
    endtask
    // Convert mode cycle
    task automatic t_convert(input logic [11:0] v, input logic poke);
        code = v;
        read_conv = 0;
        step(2);
        chk("busy_lo", 0, busy_n);
        chk("track_lo", 0, track);
        step(3);
        read_conv = 1;
        run_conv(poke, 4);
        chk("busy_hi", 1, busy_n);
        rd_bytes(v);
    endtask
    // Read mode: high pulse reads old word, fall starts
    task automatic t_readmode(input logic [11:0] old, input logic [11:0] v);
        code = v;
        sel_n = 1;
        read_conv = 0;
        step(2);
        sel_n = 0;
        step(4);
        chk("busy_rd", 1, busy_n);
        chk("oe_lo", 12'h000, data_oe);
        read_conv = 1;
        step(5);
        chk("oe_rd", 12'hfff, data_oe);
        chk("rd_old", old, data_out);
        read_conv = 0;
        step(2);
        chk("hold", old, data_out);
        chk("busy_rm", 0, busy_n);
        step(16);
        chk("oe_rm", 12'h000, data_oe);
        run_conv(0, 17);
        read_conv = 1;
        rd_bytes(v);
    endtask
    // Falls with select or upper byte high are refused
    task automatic t_inhibit(input logic s, input logic u);
        sel_n = s;
        ub = u;
        step(4);
        read_conv = 0;
        step(8);
        chk("inhib", 1, busy_n);
        read_conv = 1;
        step(8);
        chk("rise", 1, busy_n);
        sel_n = 0;
        ub = 0;
        step(4);
    endtask
    task automatic give_verdict();
        if (errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Main sequence
    initial begin
        step(2);
        chk("rst_oe", 12'h000, data_oe);
        reset = 0;
        step(1);
        chk("rst_busy", 1, busy_n);
        t_inhibit(1, 0);
        t_inhibit(0, 1);
        t_convert(12'hfff, 0);
        t_convert(12'h5a3, 1);
        t_readmode(12'h5a3, 12'h3c6);
        give_verdict();
    end
endmodule // sar_adc_conversion_control_test
